// file: core/uef_top.sv
/*
  Endpoint FIFO block top: three transmit and three receive FIFOs,
  main control, interrupt pin style and divided clock output.
  Assumes the endpoint controller and register master run on mclk.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uef_top
  import uef_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Endpoint controller, transmit side
  input wire logic [2:0] epTxTake,
  output logic [23:0] epTxData,
  output logic [2:0] txUnderrun,
  // Endpoint controller, receive side
  input wire logic [2:0] epRxStore,
  input wire logic [23:0] epRxData,
  output logic [2:0] rxOverrun,
  // Warning levels
  output logic [2:0] txLowWaterFlag,
  output logic [2:0] rxLowWaterFlag,
  // Transceiver and supply
  output logic regulatorEnable,
  output logic forceSe0,
  // Interrupt pin
  input wire logic irqRequest,
  output logic irqPinOut,
  output logic irqPinOe,
  // Divided clock
  output logic dividedClockPin
);
  // Main control state
  logic softReset; // Self-clearing reset bit
  logic clr; // Synchronous clear of all but clock config
  logic nodeAttached;
  logic regEn;
  uef_irq_style_t irqStyle;
  // Clock config state
  logic [3:0] clockOutDivisor;
  logic clockOutDisable;

  // Group decode of address
  logic [3:0] grp;
  logic [1:0] ep;
  logic epOk;
  logic wrMain;
  logic wrClk;
  // Index 3 is unmapped in every group; epOk screens it out
  assign grp = regAddr[5:2];
  assign ep = regAddr[1:0];
  assign epOk = (ep < 2'(NUM_EP));
  assign wrMain = regWr && (regAddr == ADDR_MAIN_CTRL);
  assign wrClk = regWr && (regAddr == ADDR_CLK_CONF);

  // Per-endpoint results
  logic [7:0] txStatRd [NUM_EP]; // Free count
  logic [7:0] txCtrlRd [NUM_EP];
  logic [7:0] rxStatRd [NUM_EP]; // Waiting count
  logic [7:0] rxCtrlRd [NUM_EP];
  logic [7:0] rxPeek [NUM_EP];
  logic [7:0] txPeek [NUM_EP];
  logic [2:0] next_txUnder;
  logic [2:0] next_rxOver;
  logic [2:0] next_txWarn;
  logic [2:0] next_rxWarn;
  logic [2:0] txTaken; // Take that moved a byte

  // [RULE_16] Soft reset as one-cycle clear
  assign clr = softReset;

  // One slice per endpoint; the last slice gets the large FIFO
  genvar i;
  generate
    for (i = 0; i < NUM_EP; i++)
    begin : g_ep
      localparam int D = (i == NUM_EP - 1) ? FIFO_LARGE : FIFO_SMALL;
      logic [5:0] txThr; // Tx warning threshold
      logic finalPkt; // Final packet flag
      logic [5:0] rxThr; // Rx warning threshold
      logic [6:0] txLvl;
      logic [6:0] rxLvl;
      logic txEmpty;
      logic rxFull;
      logic [6:0] txFree;
      logic [6:0] rxSpace;
      logic hitEp;
      logic wrTxc;
      logic wrRxc;
      assign hitEp = epOk && (ep == 2'(i));
      assign wrTxc = regWr && hitEp && (grp == ADDR_TX_CTRL[5:2]);
      assign wrRxc = regWr && hitEp && (grp == ADDR_RX_CTRL[5:2]);

      // Endpoint control registers
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          txThr <= 6'h00;
          finalPkt <= 1'b0;
          rxThr <= 6'h00;
        end
        else if (clr)
        begin
          // Soft reset returns thresholds to zero
          txThr <= 6'h00;
          finalPkt <= 1'b0;
          rxThr <= 6'h00;
        end
        else
        begin
          // Reserved bits simply not stored
          if (wrTxc)
          begin
            txThr <= regWdata[5:0];
            finalPkt <= regWdata[EC_FINAL];
          end
          // Rx control carries no final flag
          if (wrRxc)
            rxThr <= regWdata[5:0];
        end
      end

      // Transmit FIFO: firmware fills, controller drains
      uef_fifo #(.DEPTH(D)) u_tx (
        .clk(mclk),
        .rst_n(rst_n),
        .clr(clr),
        .flush(wrTxc && regWdata[EC_FLUSH]),
        .wrEn(regWr && hitEp && (grp == ADDR_TX_DATA[5:2])),
        .wrData(regWdata),
        .rdEn(epTxTake[i]),
        .peek(txPeek[i]),
        .level(txLvl),
        .isEmpty(txEmpty),
        .isFull()
      );

      // Receive FIFO: controller fills, firmware drains
      uef_fifo #(.DEPTH(D)) u_rx (
        .clk(mclk),
        .rst_n(rst_n),
        .clr(clr),
        .flush(wrRxc && regWdata[EC_FLUSH]),
        .wrEn(epRxStore[i]),
        .wrData(epRxData[8*i +: 8]),
        .rdEn(regRd && hitEp && (grp == ADDR_RX_DATA[5:2])),
        .peek(rxPeek[i]),
        .level(rxLvl),
        .isEmpty(),
        .isFull(rxFull)
      );

      // Seven bits so a 64-byte FIFO can report full
      assign txFree = 7'(D) - txLvl;
      assign rxSpace = 7'(D) - rxLvl;
      // [RULE_07] Free count readable
      assign txStatRd[i] = {1'b0, txFree};
      // [RULE_14] Waiting count readable
      assign rxStatRd[i] = {1'b0, rxLvl};
      assign txCtrlRd[i] = {finalPkt, 1'b0, txThr};
      assign rxCtrlRd[i] = {2'b00, rxThr};
      // Only a take that finds data moves the output byte
      assign txTaken[i] = epTxTake[i] && !txEmpty;
      // [RULE_03] Underrun on empty take
      assign next_txUnder[i] = epTxTake[i] && txEmpty && !finalPkt;
      // [RULE_12] Overrun on full store
      assign next_rxOver[i] = epRxStore[i] && rxFull;
      // [RULE_06] Tx low-water compare
      assign next_txWarn[i] = (txLvl <= {1'b0, txThr});
      // [RULE_13] Rx low-water compare
      assign next_rxWarn[i] = (rxSpace <= {1'b0, rxThr});
    end
  endgenerate

  // Read data selection; unmapped and reserved read zero
  logic [7:0] next_rdata;
  logic [7:0] mainRd;
  logic [7:0] clkRd;
  // [RULE_15] Reserved bits read zero
  assign mainRd = {irqStyle, 2'b00, nodeAttached, regEn, 1'b0, softReset};
  assign clkRd = {clockOutDisable, 3'b000, clockOutDivisor};
  // Rx data read shows the byte before its pop lands
  assign next_rdata =
    !regRd ? BYTE_RESET :
    (regAddr == ADDR_MAIN_CTRL) ? mainRd :
    (regAddr == ADDR_CLK_CONF) ? clkRd :
    !epOk ? BYTE_RESET :
    (grp == ADDR_TX_STAT[5:2]) ? txStatRd[ep] :
    (grp == ADDR_TX_CTRL[5:2]) ? txCtrlRd[ep] :
    (grp == ADDR_RX_DATA[5:2]) ? rxPeek[ep] :
    (grp == ADDR_RX_STAT[5:2]) ? rxStatRd[ep] :
    (grp == ADDR_RX_CTRL[5:2]) ? rxCtrlRd[ep] :
    BYTE_RESET;

  // Main control register and soft reset pulse
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      softReset <= 1'b0;
      nodeAttached <= 1'b0;
      regEn <= 1'b0;
      irqStyle <= IRQ_OFF;
    end
    else if (clr)
    begin
      // [RULE_16] Bit clears as reset ends
      softReset <= 1'b0;
      // [RULE_17] Regulator back off
      regEn <= 1'b0;
      nodeAttached <= 1'b0;
      irqStyle <= IRQ_OFF;
    end
    else if (wrMain)
    begin
      // Bit 0 written low leaves the soft reset idle
      softReset <= regWdata[MC_SOFT_RESET_BIT];
      regEn <= regWdata[MC_VGE];
      nodeAttached <= regWdata[MC_NAT];
      irqStyle <= uef_irq_style_t'(regWdata[MC_IRQ_LO +: 2]);
    end
  end

  // Clock config; soft reset leaves it alone on purpose
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clockOutDivisor <= CLOCK_OUT_DIVISOR_RESET;
      clockOutDisable <= 1'b0;
    end
    else if (wrClk)
    begin
      // The freeze itself lives in the divider
      clockOutDivisor <= regWdata[3:0];
      clockOutDisable <= regWdata[CC_DIS];
    end
  end

  // Interrupt pin drive per style
  logic next_irqOut;
  logic next_irqOe;
  // [RULE_20] Pin style decode
  always_comb
  begin
    next_irqOut = 1'b0;
    next_irqOe = 1'b0;
    case (irqStyle)
      IRQ_OFF:
      begin
        next_irqOut = 1'b0;
        next_irqOe = 1'b0;
      end
      IRQ_LOW_OD:
      begin
        // Pull low only while asserted
        next_irqOut = 1'b0;
        next_irqOe = irqRequest;
      end
      IRQ_HIGH_PP:
      begin
        next_irqOut = irqRequest;
        next_irqOe = 1'b1;
      end
      IRQ_LOW_PP:
      begin
        next_irqOut = !irqRequest;
        next_irqOe = 1'b1;
      end
      default:
      begin
        next_irqOut = 1'b0;
        next_irqOe = 1'b0;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdata <= BYTE_RESET;
      epTxData <= 24'h000000;
      txUnderrun <= 3'h0;
      rxOverrun <= 3'h0;
      txLowWaterFlag <= 3'h0;
      rxLowWaterFlag <= 3'h0;
      regulatorEnable <= 1'b0;
      forceSe0 <= 1'b1;
      irqPinOut <= 1'b0;
      irqPinOe <= 1'b0;
    end
    else
    begin
      regRdata <= next_rdata;
      // [RULE_16] Soft clear drops held bytes
      if (clr)
      begin
        epTxData <= 24'h000000;
      end
      else
      begin
        // Tx byte held until next successful take
        for (int k = 0; k < NUM_EP; k++)
        begin
          if (txTaken[k])
            epTxData[8*k +: 8] <= txPeek[k];
        end
      end
      // Event pulses are dropped while the soft clear runs
      txUnderrun <= clr ? 3'h0 : next_txUnder;
      rxOverrun <= clr ? 3'h0 : next_rxOver;
      // Warning levels lag the compares by one cycle
      txLowWaterFlag <= next_txWarn;
      rxLowWaterFlag <= next_rxWarn;
      // [RULE_17] Supply follows enable bit
      regulatorEnable <= regEn;
      // [RULE_18] SE0 until attached
      forceSe0 <= !nodeAttached;
      // Registered so the pad never sees decode glitches
      irqPinOut <= next_irqOut;
      irqPinOe <= next_irqOe;
    end
  end

  // Divided clock output
  // It keeps running through a soft reset on purpose
  uef_clock_out_divisor u_clk (
    .clk(mclk),
    .rst_n(rst_n),
    .divisor(clockOutDivisor),
    .freeze(clockOutDisable),
    .pinOut(dividedClockPin)
  );
endmodule : uef_top
`default_nettype wire

// file: shared/uef_pkg.sv
/*
  Shared constants for the endpoint FIFO block: register offsets, field
  positions, reset values and FIFO sizes.
  Assumes an 8-bit register port with a 6-bit word address.
*/
// Functional notes
// [RULE_01] Tx read pointer steps and wraps per take
// [RULE_02] Tx read pointer never passes write pointer
// [RULE_03] Take from empty, not final: underrun
// [RULE_04] Tx write pointer steps and wraps per write
// [RULE_05] Write into full tx FIFO is dropped
// [RULE_06] Tx warning when fill at/below threshold
// [RULE_07] Tx free count readable in status
// [RULE_08] Rx read pointer steps and wraps per read
// [RULE_09] Rx read pointer never passes write pointer
// [RULE_10] Empty rx read repeats last byte
// [RULE_11] Rx write pointer steps and wraps per store
// [RULE_12] Store into full rx FIFO: overrun
// [RULE_13] Rx warning when space at/below threshold
// [RULE_14] Rx waiting count readable in status
// [RULE_15] Reserved bits read zero, write ignored
// [RULE_16] Soft reset all but clock config, self-clears
// [RULE_17] Regulator enable resets to zero
// [RULE_18] Not attached forces SE0 on bus
// [RULE_19] Firmware attaches only after supply settles
// [RULE_20] Interrupt pin style two-bit select
// [RULE_21] Clock out divides by divisor plus one; divisor zero holds the pin high instead
// [RULE_22] Clock out disable freezes pin level
// [RULE_23] Level from pointer difference, flush zeroes
package uef_pkg;
  // Register word offsets
  localparam logic [5:0] ADDR_MAIN_CTRL = 6'h00;
  localparam logic [5:0] ADDR_CLK_CONF = 6'h01;
  localparam logic [5:0] ADDR_TX_DATA = 6'h10;
  localparam logic [5:0] ADDR_TX_STAT = 6'h14;
  localparam logic [5:0] ADDR_TX_CTRL = 6'h18;
  localparam logic [5:0] ADDR_RX_DATA = 6'h20;
  localparam logic [5:0] ADDR_RX_STAT = 6'h24;
  localparam logic [5:0] ADDR_RX_CTRL = 6'h28;
  // Main control field positions
  localparam int MC_SOFT_RESET_BIT = 0;
  localparam int MC_VGE = 2;
  localparam int MC_NAT = 3;
  localparam int MC_IRQ_LO = 6;
  // Clock config field positions
  localparam int CC_DIS = 7;
  // Endpoint control field positions
  localparam int EC_FINAL = 7;
  localparam int EC_FLUSH = 6;
  // Reset values
  localparam logic [3:0] CLOCK_OUT_DIVISOR_RESET = 4'hb;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // FIFO sizes per endpoint pair
  localparam int FIFO_SMALL = 32;
  localparam int FIFO_LARGE = 64;
  localparam int NUM_EP = 3;
  // Interrupt pin styles
  typedef enum logic [1:0] {
    IRQ_OFF = 2'h0,
    IRQ_LOW_OD = 2'h1,
    IRQ_HIGH_PP = 2'h2,
    IRQ_LOW_PP = 2'h3
  } uef_irq_style_t;
endpackage : uef_pkg

// file: core/uef_fifo.sv
/*
  Byte FIFO with wrapping pointers, full tracking and a peek port.
  Assumes DEPTH is a power of two and all strobes are on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module uef_fifo
  import uef_pkg::*;
#(
  parameter int DEPTH = 32
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic flush,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic rdEn,
  output logic [7:0] peek,
  output logic [6:0] level,
  output logic isEmpty,
  output logic isFull
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH]; // Byte storage
  logic [AW-1:0] wp; // Write pointer
  logic [AW-1:0] rp; // Read pointer
  logic [AW-1:0] diff; // Pointer difference
  logic full; // Disambiguates equal pointers
  logic [7:0] last; // Most recent byte taken
  logic doWr;
  logic doRd;
  // [RULE_05] Full blocks write
  assign doWr = wrEn && !full;
  // [RULE_02] [RULE_09] Empty blocks read
  assign doRd = rdEn && !isEmpty;
  // [RULE_23] Level by pointer difference
  assign diff = wp - rp;
  assign isFull = full;
  assign isEmpty = !full && (wp == rp);
  assign level = full ? 7'(DEPTH) : 7'(diff);
  // [RULE_10] Empty peek gives last byte
  assign peek = isEmpty ? last : mem[rp];

  // Storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (doWr)
    begin
      mem[wp] <= wrData;
    end
  end

  // Pointers; power-of-two size wraps naturally
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      rp <= '0;
      full <= 1'b0;
      last <= BYTE_RESET;
    end
    else if (clr || flush)
    begin
      // [RULE_23] Flush zeroes pointers
      wp <= '0;
      rp <= '0;
      full <= 1'b0;
      last <= BYTE_RESET;
    end
    else
    begin
      // [RULE_04] [RULE_11] Step write pointer
      if (doWr)
        wp <= wp + 1'b1;
      // [RULE_01] [RULE_08] Step read pointer
      if (doRd)
      begin
        rp <= rp + 1'b1;
        last <= mem[rp];
      end
      if (doWr && !doRd && (AW'(wp + 1'b1) == rp))
        full <= 1'b1;
      else if (doRd && !doWr)
        full <= 1'b0;
    end
  end
endmodule : uef_fifo
`default_nettype wire

// file: core/uef_clock_out_divisor.sv
/*
  Divided clock output: period of divisor plus one clocks.
  Assumes divisor and disable come from registers on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module uef_clock_out_divisor
  import uef_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] divisor,
  input wire logic freeze,
  output logic pinOut
);
  logic [3:0] cnt; // Position within period
  logic [3:0] next_cnt;
  logic [3:0] half; // High phase length
  // Compare against live divisor: a change stretches or cuts
  // the running phase instead of restarting it, so no runt pulse
  assign next_cnt = (cnt >= divisor) ? 4'h0 : cnt + 4'h1;
  assign half = 4'((5'(divisor) + 5'h1) >> 1);

  // Divider; divisor zero holds the pin high (cannot split a clock)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      pinOut <= 1'b0;
    end
    // [RULE_22] Frozen at present level
    else if (!freeze)
    begin
      // [RULE_21] Divide by divisor plus one
      cnt <= next_cnt;
      pinOut <= (next_cnt < half) || (divisor == 4'h0);
    end
  end
endmodule : uef_clock_out_divisor
`default_nettype wire

// file: verification/uef_properties.sv
/*
  Port checker for the endpoint FIFO top, bound to uef_top.
  Assumes one clock, mclk, and the async active-low rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module uef_properties
  import uef_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [2:0] epTxTake,
  input wire logic [23:0] epTxData,
  input wire logic [2:0] txUnderrun,
  input wire logic [2:0] epRxStore,
  input wire logic [2:0] rxOverrun,
  input wire logic regulatorEnable,
  input wire logic forceSe0,
  input wire logic dividedClockPin
);
  // Register write decodes
  wire logic wrMain = regWr && (regAddr == ADDR_MAIN_CTRL);
  wire logic wrClk = regWr && (regAddr == ADDR_CLK_CONF);
  // Soft reset window; outputs jump there, so checks pause
  logic [3:0] srstNear;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srstNear <= 4'h0;
    end
    else
    begin
      srstNear <= {srstNear[2:0], wrMain && regWdata[0]};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n || (|srstNear));
  a_underrun_cause: assert property (txUnderrun[0] |-> $past(epTxTake[0]))
    else $error("underrun without take");
  a_underrun_nodata: assert property (txUnderrun[0] |-> $stable(epTxData[7:0]))
    else $error("empty take moved data");
  a_txdata_hold: assert property (!epTxTake[0] |=> $stable(epTxData[7:0]))
    else $error("tx data moved without take");
  a_overrun_cause: assert property (rxOverrun[0] |-> $past(epRxStore[0]))
    else $error("overrun without store");
  a_attach_drive: assert property (wrMain && !regWdata[0] |=> ##1 forceSe0 == !$past(regWdata[3], 2))
    else $error("se0 not per attach bit");
  a_regulator_write: assert property (wrMain && !regWdata[0] |=> ##1 regulatorEnable == $past(regWdata[2], 2))
    else $error("regulator not per bit");
  a_clock_freeze: assert property (wrClk && regWdata[7] |=> ##1 $stable(dividedClockPin)[*4])
    else $error("frozen clock moved");
  a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside read");
  c_underrun: cover property (txUnderrun[0]);
  c_overrun: cover property (rxOverrun[0]);
  c_freeze: cover property (wrClk && regWdata[7]);
endmodule : uef_properties
bind uef_top uef_properties CHK (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .epTxTake, .epTxData, .txUnderrun, .epRxStore, .rxOverrun, .regulatorEnable, .forceSe0,
  .dividedClockPin);
`default_nettype wire

// file: verification/uef_ep_model.sv
/*
  Endpoint controller model: takes tx bytes, stores rx bytes.
  Assumes callers run in the mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module uef_ep_model
  import uef_pkg::*;
(
  input wire logic mclk,
  output logic [2:0] epTxTake,
  output logic [2:0] epRxStore,
  output logic [23:0] epRxData
);
  // Idle strobes; data lane holds no valid byte
  initial
  begin
    epTxTake = 3'h0;
    epRxStore = 3'h0;
    epRxData = 24'h5aa55a;
  end
  // One-cycle take on endpoint k
  task automatic take(input int k);
    @(posedge mclk);
    epTxTake[k] <= 1'b1;
    @(posedge mclk);
    epTxTake <= 3'h0;
  endtask : take
  // Store one byte; lane inverted after, so stale data never matches
  task automatic store(input int k, input logic [7:0] b);
    @(posedge mclk);
    epRxStore[k] <= 1'b1;
    epRxData[8*k +: 8] <= b;
    @(posedge mclk);
    epRxStore <= 3'h0;
    epRxData[8*k +: 8] <= ~b;
  endtask : store
endmodule : uef_ep_model
`default_nettype wire

// file: verification/uef_top_tb.sv
/*
  Self-checking bench for uef_top, endpoint 0 of each direction, plus the endpoint 2 tx free count at reset.
  Assumes the endpoint model drives the controller side.
*/
`timescale 1ns/1ps
`default_nettype none
`define UEF_CHK(got, exp) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module uef_top_tb
  import uef_pkg::*;
;
  logic mclk, rst_n, regWr, regRd, irqRequest;
  logic [5:0] regAddr;
  logic [7:0] regWdata;
  wire logic [7:0] regRdata;
  wire logic [2:0] epTxTake, txUnderrun, epRxStore, rxOverrun, txLowWaterFlag, rxLowWaterFlag;
  wire logic [23:0] epTxData, epRxData;
  wire logic regulatorEnable, forceSe0, irqPinOut, irqPinOe, dividedClockPin;
  int fails = 0;
  int testsRun = 0;
  int cycles = 0;
  uef_top DUT (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .epTxTake,
    .epTxData, .txUnderrun, .epRxStore, .epRxData, .rxOverrun, .txLowWaterFlag,
    .rxLowWaterFlag, .regulatorEnable, .forceSe0, .irqRequest, .irqPinOut, .irqPinOe,
    .dividedClockPin);
  uef_ep_model EP (.mclk, .epTxTake, .epRxStore, .epRxData);
  // Clock and hang guard
  always #25 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      completeRun();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic testReset();
    logic [7:0] d;
    rd(ADDR_MAIN_CTRL, d);
    `UEF_CHK(d, 8'h00);
    rd(ADDR_CLK_CONF, d);
    `UEF_CHK(d, {4'h0, CLOCK_OUT_DIVISOR_RESET});
    `UEF_CHK({regulatorEnable, forceSe0}, 2'b01);
    `UEF_CHK(txLowWaterFlag, 3'h7);
    `UEF_CHK(rxLowWaterFlag, 3'h0);
    rd(ADDR_TX_STAT + 6'h2, d);
    `UEF_CHK(d, 8'd64);
    rd(6'h3f, d);
    `UEF_CHK(d, 8'h00);
    $display("reset test done");
  endtask : testReset
  task automatic testTx();
    logic [7:0] d;
    wr(ADDR_TX_CTRL, 8'h04);
    for (int i = 0; i < 33; i++) wr(ADDR_TX_DATA, 8'(i + 64));
    rd(ADDR_TX_STAT, d);
    `UEF_CHK(d, 8'h00);
    `UEF_CHK(txLowWaterFlag[0], 1'b0);
    for (int i = 0; i < 32; i++)
    begin
      EP.take(0);
      #1;
      `UEF_CHK(epTxData[7:0], 8'(i + 64));
      if (i == 26 || i == 27)
      begin
        cyc(2);
        `UEF_CHK(txLowWaterFlag[0], 1'(i == 27));
      end
    end
    rd(ADDR_TX_STAT, d);
    `UEF_CHK(d, 8'd32);
    EP.take(0);
    #1;
    `UEF_CHK({txUnderrun[0], epTxData[7:0]}, 9'h15f);
    wr(ADDR_TX_CTRL, 8'h84);
    EP.take(0);
    #1;
    `UEF_CHK({txUnderrun[0], epTxData[7:0]}, 9'h05f);
    wr(ADDR_TX_DATA, 8'ha5);
    EP.take(0);
    #1;
    `UEF_CHK(epTxData[7:0], 8'ha5);
    $display("tx test done");
  endtask : testTx
  task automatic testRx();
    logic [7:0] d;
    wr(ADDR_RX_CTRL, 8'h02);
    for (int i = 0; i < 32; i++)
    begin
      EP.store(0, 8'(i + 128));
      if (i == 28 || i == 29)
      begin
        cyc(2);
        `UEF_CHK(rxLowWaterFlag[0], 1'(i == 29));
      end
    end
    EP.store(0, 8'h11);
    #1;
    `UEF_CHK(rxOverrun[0], 1'b1);
    rd(ADDR_RX_STAT, d);
    `UEF_CHK(d, 8'd32);
    for (int i = 0; i < 33; i++)
    begin
      rd(ADDR_RX_DATA, d);
      `UEF_CHK(d, 8'(i > 31 ? 159 : i + 128));
    end
    rd(ADDR_RX_STAT, d);
    `UEF_CHK(d, 8'd0);
    EP.store(0, 8'h3c);
    rd(ADDR_RX_DATA, d);
    `UEF_CHK(d, 8'h3c);
    rd(ADDR_RX_STAT, d);
    `UEF_CHK(d, 8'd0);
    EP.store(0, 8'h99);
    wr(ADDR_RX_CTRL, 8'h40);
    rd(ADDR_RX_STAT, d);
    `UEF_CHK(d, 8'd0);
    $display("rx test done");
  endtask : testRx
  task automatic testControl();
    logic [7:0] d;
    wr(ADDR_MAIN_CTRL, 8'h04);
    cyc(20000);
    wr(ADDR_MAIN_CTRL, 8'h0c);
    rd(ADDR_MAIN_CTRL, d);
    `UEF_CHK({d, regulatorEnable, forceSe0}, 10'h032);
    for (int s = 0; s < 8; s++)
    begin
      wr(ADDR_MAIN_CTRL, {2'(s >> 1), 6'h0c});
      irqRequest <= 1'(s);
      cyc(3);
      `UEF_CHK({irqPinOut, irqPinOe}, {1'(s == 5 || s == 6), 1'(s > 2)});
    end
    $display("control test done");
  endtask : testControl
  task automatic testClock();
    int n;
    logic p;
    wr(ADDR_CLK_CONF, 8'h03);
    cyc(30);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      p = dividedClockPin;
      while (!(dividedClockPin && !p) && n < 40)
      begin
        p = dividedClockPin;
        cyc(1);
        n++;
      end
    end
    `UEF_CHK(n, 4);
    wr(ADDR_CLK_CONF, 8'h83);
    cyc(1);
    p = dividedClockPin;
    cyc(10);
    `UEF_CHK(dividedClockPin, p);
    wr(ADDR_CLK_CONF, 8'h03);
    $display("clock test done");
  endtask : testClock
  task automatic testSoftReset();
    logic [7:0] d;
    wr(ADDR_TX_DATA, 8'h77);
    wr(ADDR_MAIN_CTRL, 8'h0d);
    cyc(4);
    rd(ADDR_MAIN_CTRL, d);
    `UEF_CHK({d, regulatorEnable, forceSe0}, 10'h001);
    `UEF_CHK(epTxData, 24'h000000);
    rd(ADDR_CLK_CONF, d);
    `UEF_CHK(d, 8'h03);
    rd(ADDR_TX_STAT, d);
    `UEF_CHK(d, 8'd32);
    $display("soft reset test done");
  endtask : testSoftReset
  task automatic completeRun();
    $display("compares %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : completeRun
  // Main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    regAddr = 6'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    irqRequest = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    testReset();
    testTx();
    testRx();
    testControl();
    testClock();
    testSoftReset();
    completeRun();
  end
endmodule : uef_top_tb
`default_nettype wire
